// ---- core/ccmu_unit.sv ----
// code conversion and table move unit: accumulator conversions and
// word table operations on a 16-bit word memory
// assumes the sequencer holds req stable while req_valid and not busy,
// and memory returns read data in the cycle after mem.rd is shown
//
// Contract
// - each source word yields two ascii words
// - ascii table starts at instruction operand address
// - digits 0-9 to 30-39, A-F to 41-46
// - four accumulator digits become segment patterns
// - gray 16-bit to 10-bit bcd, upper bits zero
// - reorder up to eight digits, result in accumulator
// - order digit names target position of source digit
// - order 0 or 9-F discards the source digit
// - duplicate targets take most significant order digit
// - copy count words to operand destination address
// - accumulator is 32 bits wide
`timescale 1ns/1ns
module ccmu_unit
  import ccmu_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // request from sequencer
  input  wire logic       req_valid,
  input  wire ccmu_req_t  req,
  output logic            busy,
  // answer to sequencer
  output logic            done,
  output logic     [31:0] acc_out,
  // word memory
  output ccmu_mem_t       mem,
  input  wire logic [15:0] mem_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_data,
    st_write_a,
    st_write_b
  } ccmu_state_t;

  ccmu_state_t        state_ff;
  ccmu_state_t        nxt_state;
  ccmu_op_t           op_ff;
  ccmu_op_t           nxt_op;
  ccmu_mem_t          mem_ff;
  ccmu_mem_t          nxt_mem;
  logic [15:0]        src_ff;
  logic [15:0]        nxt_src;
  logic [15:0]        dst_ff;
  logic [15:0]        nxt_dst;
  logic [15:0]        cnt_ff;
  logic [15:0]        nxt_cnt;
  logic [15:0]        hold_ff;
  logic [15:0]        nxt_hold;
  logic [CCMU_ACC_W-1:0] acc_ff;
  logic [CCMU_ACC_W-1:0] nxt_acc;
  logic               done_ff;
  logic               nxt_done;

  // ----------------------------------------------------------------
  // digit converters
  // ----------------------------------------------------------------
  logic [15:0]        conv_word;
  logic [7:0]         ascii_b [CCMU_WORD_DIGITS];
  logic [7:0]         glyph_b [CCMU_WORD_DIGITS];
  logic [15:0]        ascii_hi;
  logic [15:0]        ascii_lo;
  logic [31:0]        seg_word;

  // table data while a read answers, else the accumulator digits
  assign conv_word = (state_ff == st_data) ? mem_rdata
                                           : req.acc[15:0];

  genvar gi;
  generate
    for (gi = 0; gi < CCMU_WORD_DIGITS; gi++)
    begin : g_digit
      ccmu_digit_conv u_conv (
        .nibble (conv_word[gi*CCMU_NIB_W +: CCMU_NIB_W]),
        .ascii  (ascii_b[gi]),
        .glyph  (glyph_b[gi])
      );
    end
  endgenerate

  assign ascii_hi = {ascii_b[3], ascii_b[2]};
  assign ascii_lo = {ascii_b[1], ascii_b[0]};
  assign seg_word = {glyph_b[3], glyph_b[2], glyph_b[1], glyph_b[0]};

  // ----------------------------------------------------------------
  // gray code to bcd
  // ----------------------------------------------------------------
  function automatic logic [31:0] gray_to_bcd(input logic [15:0] g);
    logic [15:0]                   bin;
    logic [CCMU_BCD_DIGITS*4-1:0] bcd;
    bin = CCMU_ZERO;
    bcd = '0;
    bin[15] = g[15];
    for (int i = 14; i >= 0; i--)
      bin[i] = bin[i+1] ^ g[i];
    for (int i = 15; i >= 0; i--)
    begin
      for (int d = 0; d < CCMU_BCD_DIGITS; d++)
        if (bcd[d*4 +: 4] >= CCMU_BCD_ADJ_LIMIT)
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + CCMU_BCD_ADJ;
      bcd = {bcd[CCMU_BCD_DIGITS*4-2:0], bin[i]};
    end
    // only the low 10 bcd bits are kept, the rest cleared
    return {22'h00_0000, bcd[CCMU_BCD_BITS-1:0]};
  endfunction

  // ----------------------------------------------------------------
  // digit reorder
  // ----------------------------------------------------------------
  function automatic logic [31:0] reorder(input logic [31:0] src,
                                          input logic [31:0] order);
    logic [31:0] res;
    logic [3:0]  pos;
    res = '0;
    // ascending scan so the most significant duplicate lands last
    for (int i = 0; i < CCMU_SHUF_DIGITS; i++)
    begin
      pos = order[i*4 +: 4];
      if (pos >= CCMU_SHUF_POS_MIN && pos <= CCMU_SHUF_POS_MAX)
        res[(int'(pos) - 1)*4 +: 4] = src[i*4 +: 4];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_op    = op_ff;
    nxt_mem   = '0;
    nxt_src   = src_ff;
    nxt_dst   = dst_ff;
    nxt_cnt   = cnt_ff;
    nxt_hold  = hold_ff;
    nxt_acc   = acc_ff;
    nxt_done  = 1'b0;
    unique case (state_ff)
      st_idle:
      begin
        if (req_valid)
        begin
          nxt_op  = req.op;
          nxt_acc = req.acc;
          unique case (req.op)
            digit_display_encode_op:
            begin
              nxt_acc  = seg_word;
              nxt_done = 1'b1;
            end
            gray_to_bcd_op:
            begin
              nxt_acc  = gray_to_bcd(req.acc[15:0]);
              nxt_done = 1'b1;
            end
            digit_reorder_op:
            begin
              nxt_acc  = reorder(req.stack, req.acc);
              nxt_done = 1'b1;
            end
            hex_to_ascii_op, table_copy_op:
            begin
              nxt_src = req.acc[15:0];
              nxt_dst = req.operand;
              nxt_cnt = req.stack[15:0];
              if (req.stack[15:0] == CCMU_ZERO)
                nxt_done = 1'b1;
              else
              begin
                nxt_mem.rd   = 1'b1;
                nxt_mem.addr = req.acc[15:0];
                nxt_state    = st_read;
              end
            end
            default:
              nxt_done = 1'b1;
          endcase
        end
      end
      st_read:
        nxt_state = st_data;
      st_data:
      begin
        nxt_mem.wr   = 1'b1;
        nxt_mem.addr = dst_ff;
        if (op_ff == hex_to_ascii_op)
        begin
          nxt_mem.wdata = ascii_hi;
          nxt_hold      = ascii_lo;
        end
        else
          nxt_mem.wdata = mem_rdata;
        nxt_dst   = dst_ff + CCMU_ONE;
        nxt_state = st_write_a;
      end
      st_write_a, st_write_b:
      begin
        if (state_ff == st_write_a && op_ff == hex_to_ascii_op)
        begin
          nxt_mem.wr    = 1'b1;
          nxt_mem.addr  = dst_ff;
          nxt_mem.wdata = hold_ff;
          nxt_dst       = dst_ff + CCMU_ONE;
          nxt_state     = st_write_b;
        end
        else
        begin
          nxt_cnt = cnt_ff - CCMU_ONE;
          nxt_src = src_ff + CCMU_ONE;
          if (cnt_ff == CCMU_ONE)
          begin
            nxt_done  = 1'b1;
            nxt_state = st_idle;
          end
          else
          begin
            nxt_mem.rd   = 1'b1;
            nxt_mem.addr = src_ff + CCMU_ONE;
            nxt_state    = st_read;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= st_idle;
      op_ff    <= hex_to_ascii_op;
      mem_ff   <= '0;
      src_ff   <= '0;
      dst_ff   <= '0;
      cnt_ff   <= '0;
      hold_ff  <= '0;
      acc_ff   <= '0;
      done_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      mem_ff   <= nxt_mem;
      src_ff   <= nxt_src;
      dst_ff   <= nxt_dst;
      cnt_ff   <= nxt_cnt;
      hold_ff  <= nxt_hold;
      acc_ff   <= nxt_acc;
      done_ff  <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy    = (state_ff != st_idle);
  assign done    = done_ff;
  assign acc_out = acc_ff;
  assign mem     = mem_ff;

endmodule

// ---- core/ccmu_pkg.sv ----
// code conversion and table move unit: shared types and constants
// assumes one processor clock and an instruction sequencer as requester
package ccmu_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CCMU_ACC_W        = 32;
  localparam int CCMU_WORD_W       = 16;
  localparam int CCMU_NIB_W        = 4;
  localparam int CCMU_WORD_DIGITS  = 4;
  localparam int CCMU_SHUF_DIGITS  = 8;
  localparam int CCMU_BCD_BITS     = 10;
  localparam int CCMU_BCD_DIGITS   = 5;

  // ----------------------------------------------------------------
  // conversion constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CCMU_ASCII_NUM_BASE   = 8'h30;
  localparam logic [7:0] CCMU_ASCII_ALPHA_BASE = 8'h41;
  localparam logic [3:0] CCMU_HEX_ALPHA_FIRST  = 4'ha;
  localparam logic [3:0] CCMU_SHUF_POS_MIN     = 4'h1;
  localparam logic [3:0] CCMU_SHUF_POS_MAX     = 4'h8;
  localparam logic [3:0] CCMU_BCD_ADJ_LIMIT    = 4'h5;
  localparam logic [3:0] CCMU_BCD_ADJ          = 4'h3;
  localparam logic [15:0] CCMU_ONE             = 16'h0001;
  localparam logic [15:0] CCMU_ZERO            = 16'h0000;

  // common cathode glyphs, segment a in bit 0, bit 7 clear
  localparam logic [7:0] CCMU_SEG_GLYPH [16] = '{
    8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71
  };

  // ----------------------------------------------------------------
  // operations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    hex_to_ascii_op,
    digit_display_encode_op,
    gray_to_bcd_op,
    digit_reorder_op,
    table_copy_op
  } ccmu_op_t;

  typedef struct packed {
    ccmu_op_t         op;
    logic [31:0]      acc;
    logic [31:0]      stack;
    logic [15:0]      operand;
  } ccmu_req_t;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [15:0]      addr;
    logic [15:0]      wdata;
  } ccmu_mem_t;

endpackage

// ---- core/ccmu_digit_conv.sv ----
// one hex digit to its ascii code and its seven segment glyph
// assumes a plain nibble input; purely combinational
`timescale 1ns/1ns
module ccmu_digit_conv
  import ccmu_pkg::*;
(
  // digit in
  input  wire logic [3:0] nibble,
  // conversions out
  output logic      [7:0] ascii,
  output logic      [7:0] glyph
);

  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  always_comb
  begin
    if (nibble < CCMU_HEX_ALPHA_FIRST)
      ascii = CCMU_ASCII_NUM_BASE + {4'h0, nibble};
    else
      ascii = CCMU_ASCII_ALPHA_BASE
            + {4'h0, nibble - CCMU_HEX_ALPHA_FIRST};
    glyph = CCMU_SEG_GLYPH[nibble];
  end

endmodule

// ---- testbench/ccmu_mem_model.sv ----
// word memory on the far side of the unit's memory port
// assumes one read latency cycle and no stall, as the unit expects
`timescale 1ns/1ns
module ccmu_mem_model
  import ccmu_pkg::*;
(
  // clock
  input  wire logic        clock,
  // memory port
  input  wire ccmu_mem_t   mem,
  output logic      [15:0] mem_rdata
);
  logic [15:0] words [64];
  initial mem_rdata = 16'h0000;
  // read data valid only in the cycle after a read; scrambled otherwise
  always @(posedge clock)
  begin
    if (mem.rd)
      mem_rdata <= words[mem.addr[5:0]];
    else
      mem_rdata <= ~mem_rdata;
    if (mem.wr)
      words[mem.addr[5:0]] <= mem.wdata;
  end
endmodule

// ---- testbench/ccmu_unit_checker.sv ----
// assertions on the ports of the conversion and table move unit
// assumes the unit's single clock and active low reset
`timescale 1ns/1ns
module ccmu_unit_checker
  import ccmu_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // sequencer side
  input  wire logic        req_valid,
  input  wire ccmu_req_t   req,
  input  wire logic        busy,
  input  wire logic        done,
  input  wire logic [31:0] acc_out,
  // memory side
  input  wire ccmu_mem_t   mem,
  input  wire logic [15:0] mem_rdata
);
  logic take;
  assign take = req_valid && !busy;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_single_done: assert property (
    take && req.op inside {digit_display_encode_op, gray_to_bcd_op,
    digit_reorder_op} |=> done && !busy) else $error("no single done");
  chk_gray_upper: assert property (
    take && req.op == gray_to_bcd_op |=> acc_out[31:10] == 22'h0)
    else $error("gray upper bits set");
  chk_seg_glyph: assert property (
    take && req.op == digit_display_encode_op |=> acc_out[7:0] ==
    CCMU_SEG_GLYPH[$past(req.acc[3:0])] && !acc_out[15])
    else $error("bad glyph");
  chk_copy_first: assert property (
    take && req.op == table_copy_op && req.stack[15:0] != 16'h0000
    |=> mem.rd && mem.addr == $past(req.acc[15:0]))
    else $error("bad first read");
  chk_rd_then_wr: assert property (
    mem.rd |=> !mem.wr ##1 mem.wr) else $error("write not after read");
  chk_idle_quiet: assert property (
    !busy |-> !mem.rd && !mem.wr) else $error("memory use while idle");
  chk_done_ends: assert property (
    busy ##1 !busy |-> done) else $error("busy fell without done");
  chk_order_zero: assert property (
    take && req.op == digit_reorder_op && req.acc == 32'h0000_0000
    |=> acc_out == 32'h0000_0000) else $error("discard not zero");
endmodule
bind ccmu_unit ccmu_unit_checker u_ccmu_unit_checker (.clock(clock),
  .rst_n(rst_n), .req_valid(req_valid), .req(req), .busy(busy),
  .done(done), .acc_out(acc_out), .mem(mem), .mem_rdata(mem_rdata));

// ---- testbench/ccmu_unit_tb_top.sv ----
// self-checking bench of the conversion and table move unit
// assumes the memory model answers reads one cycle later
`timescale 1ns/1ns
module ccmu_unit_tb_top
  import ccmu_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  ccmu_req_t   req = '0;
  logic        busy;
  logic        done;
  logic [31:0] acc_out;
  ccmu_mem_t   mem;
  logic [15:0] mem_rdata;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  ccmu_unit u_ccmu_unit (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .busy(busy), .done(done),
    .acc_out(acc_out), .mem(mem), .mem_rdata(mem_rdata));
  ccmu_mem_model u_ccmu_mem_model (.clock(clock), .mem(mem),
    .mem_rdata(mem_rdata));
  initial
  begin
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // sequencer loads stack and accumulator, then issues the operation
  task automatic run(input ccmu_op_t op, input logic [31:0] acc,
                     input logic [31:0] stack, input logic [15:0] dst);
    int n;
    @(posedge clock);
    req <= '{op: op, acc: acc, stack: stack, operand: dst};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check({31'h0, done}, 32'h0000_0001);
  endtask
  task automatic t_hex_ascii;
    run(hex_to_ascii_op, 32'h0000_0010, 32'h0000_0002, 16'h0020);
    check(u_ccmu_mem_model.words[32], 32'h0000_3031);
    check(u_ccmu_mem_model.words[33], 32'h0000_3233);
    check(u_ccmu_mem_model.words[34], 32'h0000_3839);
    check(u_ccmu_mem_model.words[35], 32'h0000_4146);
    check(u_ccmu_mem_model.words[36], 32'h0000_5a5a);
  endtask
  task automatic t_copy;
    run(table_copy_op, 32'h0000_0010, 32'h0000_0003, 16'h0030);
    check(u_ccmu_mem_model.words[48], 32'h0000_0123);
    check(u_ccmu_mem_model.words[49], 32'h0000_89af);
    check(u_ccmu_mem_model.words[50], 32'h0000_c0de);
    check(u_ccmu_mem_model.words[51], 32'h0000_5a5a);
    check(acc_out, 32'h0000_0010);
    run(table_copy_op, 32'h0000_0011, 32'h0000_0000, 16'h0033);
    check(u_ccmu_mem_model.words[51], 32'h0000_5a5a);
  endtask
  task automatic t_single;
    run(digit_display_encode_op, 32'hffff_1b8f, 32'h0, 16'h0);
    check(acc_out, 32'h067c_7f71);
    // a 300 count encoder value needs no correction by the program
    run(gray_to_bcd_op, 32'h5a5a_01ba, 32'h0, 16'h0);
    check(acc_out, 32'h0000_0300);
    run(digit_reorder_op, 32'h12f3_3408, 32'h8765_4321, 16'h0);
    check(acc_out, 32'h1000_3578);
    // reversed order word: source lsd goes to result msd
    run(digit_reorder_op, 32'h1234_5678, 32'h8765_4321, 16'h0);
    check(acc_out, 32'h1234_5678);
    run(digit_reorder_op, 32'h0000_0000, 32'h8765_4321, 16'h0);
    check(acc_out, 32'h0000_0000);
    // an undefined operation code leaves the accumulator as loaded
    run(ccmu_op_t'(3'h5), 32'h1357_9bdf, 32'h0, 16'h0);
    check(acc_out, 32'h1357_9bdf);
  endtask
  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 64; i++)
      u_ccmu_mem_model.words[i] = 16'h5a5a;
    u_ccmu_mem_model.words[16] = 16'h0123;
    u_ccmu_mem_model.words[17] = 16'h89af;
    u_ccmu_mem_model.words[18] = 16'hc0de;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_hex_ascii();
    t_copy();
    t_single();
    summarize();
  end
  initial
  begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule
